// file: design/wbc_cfg.svh
// Offsets, field positions, reset values and decode constants of the boost control bank
`ifndef WBC_CFG_SVH
`define WBC_CFG_SVH

// Register offsets on the serial bus
`define WBC_RESERVED_STATUS_A_OFF  8'h40
`define WBC_RESERVED_STATUS_B_OFF  8'h41
`define WBC_BOOST_ENABLE_STATUS_OFF 8'h42
`define WBC_STRING_CLAMP_SETTING_OFF 8'h43

// Field positions in boost_enable_status
`define WBC_ON_BIT  0
`define WBC_OK_BIT  1
`define WBC_WE_BIT  2

// Reset values
`define WBC_CLAMP_CODE_RST  6'h3F
`define WBC_ON_RST          1'b0
`define WBC_WE_RST          1'b0

// Clamp decode in units of 10 mV
`define WBC_LO_BASE   12'h1F4
`define WBC_LO_COARSE 12'h0C8
`define WBC_LO_FINE   12'h019
`define WBC_HI_BASE   12'h514
`define WBC_HI_COARSE 12'h190
`define WBC_HI_FINE   12'h032
`define WBC_CLAMP_MAX 12'hB22

`endif

// file: design/wbc_clamp_decode.sv
// Decoder from string clamp code to clamp voltage in 10 mV units
`include "wbc_cfg.svh"

module wbc_clamp_decode (
  input  wire logic [5:0]  code_in,
  output logic      [11:0] clamp_out
);

  logic [11:0] coarse;
  logic [11:0] fine;

  // Two ranges: the upper one doubles both step sizes
  always_comb
  begin
    coarse = 12'h000;
    fine   = 12'h000;
    if (code_in[5])
    begin
      coarse = 12'(`WBC_HI_COARSE * code_in[4:3]);
      fine   = 12'(`WBC_HI_FINE * code_in[2:0]);
      clamp_out = 12'(`WBC_HI_BASE + coarse + fine);  // RULE_10
    end
    else
    begin
      coarse = 12'(`WBC_LO_COARSE * code_in[4:3]);
      fine   = 12'(`WBC_LO_FINE * code_in[2:0]);
      clamp_out = 12'(`WBC_LO_BASE + coarse + fine);  // RULE_10
    end
  end

endmodule // wbc_clamp_decode

// file: design/wbc_pkg.sv
// Types shared by the boost control bank
package wbc_pkg;

  // Serial slave states, one-hot
  typedef enum logic [8:0] {
    WBC_IDLE      = 9'h001,
    WBC_ADDR      = 9'h002,
    WBC_ADDR_ACK  = 9'h004,
    WBC_PTR       = 9'h008,
    WBC_PTR_ACK   = 9'h010,
    WBC_WDATA     = 9'h020,
    WBC_WDATA_ACK = 9'h040,
    WBC_RDATA     = 9'h080,
    WBC_RDATA_ACK = 9'h100
  } wbc_state_t;

endpackage

// file: design/wbc_regs.sv
// Boost regulator control and status bank with its serial slave
// Operation
// RULE_01 - Reserved registers and upper bits are read-only
// RULE_02 - Enable pin high turns the boost on
// RULE_03 - Control bit 0 is read/write enable bit
// RULE_04 - Key press low also turns boost on
// RULE_05 - No enabling condition means boost off
// RULE_06 - Control bit 1 reads power-good state
// RULE_07 - Over-voltage on string clears power-good
// RULE_08 - Host writes bit 2 only with default
// RULE_09 - Threshold bits 5:0 select clamp level
// RULE_10 - Code decodes to two stepped voltage ranges
// RULE_11 - Clamp code resets to all ones
// RULE_12 - Writes to read-only bits are ignored
`include "wbc_cfg.svh"

module wbc_regs #(
  parameter logic [6:0] DEV_ADDR    = 7'h5A,  // Arbitrary bus address
  parameter logic [7:0] RESV_A_VAL  = 8'h00,  // Arbitrary reserved content
  parameter logic [7:0] RESV_B_VAL  = 8'h00,  // Arbitrary reserved content
  parameter logic       WE_DEFAULT  = `WBC_WE_RST
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        boost_enable_pin_in,
  input  wire logic        key_press_n_in,
  input  wire logic        string_top_sense_in,
  output logic             boost_en_out,
  output logic             power_good_out,
  output logic [5:0]       clamp_code_out,
  output logic [11:0]      clamp_mv_out
);

  // Pin synchronisers: scl, sda, enable pin, key, over-voltage comparator
  logic [4:0]  meta_r;
  logic [4:0]  sync_r;
  logic        scl_prev_r;
  logic        sda_prev_r;
  logic        scl_s;
  logic        sda_s;
  logic        pin_s;
  logic        key_n_s;
  logic        sense_s;

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= 5'h13;  // Idle bus high, key released, pin and sense low
      sync_r <= 5'h13;
    end
    else
    begin
      meta_r <= {key_press_n_in, boost_enable_pin_in, string_top_sense_in, sda_in, scl_in};
      sync_r <= meta_r;
    end
  end

  assign scl_s   = sync_r[0];
  assign sda_s   = sync_r[1];
  assign sense_s = sync_r[2];
  assign pin_s   = sync_r[3];
  assign key_n_s = sync_r[4];

  // Previous bus levels for edge and start/stop detection
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end
    else
    begin
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_s & ~scl_prev_r;
  assign scl_fall  = ~scl_s & scl_prev_r;
  assign start_det = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
  assign stop_det  = scl_s & scl_prev_r & ~sda_prev_r & sda_s;

  // Register storage
  logic        on_r;
  logic        we_r;
  logic [5:0]  code_r;
  logic        pg_r;
  logic        en_r;

  // Serial slave state and byte pointer, declared before the read mux uses them
  wbc_pkg::wbc_state_t state_r;
  logic [3:0]  cnt_r;
  logic [7:0]  shift_r;
  logic [7:0]  ptr_r;
  logic        rw_r;
  logic        nack_r;
  logic        wr_stb_r;
  logic [7:0]  wr_data_r;
  logic [7:0]  wr_addr_r;

  // Read mux; reserved bits read as zero
  logic [7:0] rd_data;

  always_comb
  begin
    rd_data = 8'h00;
    if (ptr_r == `WBC_RESERVED_STATUS_A_OFF)
      rd_data = RESV_A_VAL;  // RULE_01
    else if (ptr_r == `WBC_RESERVED_STATUS_B_OFF)
      rd_data = RESV_B_VAL;  // RULE_01
    else if (ptr_r == `WBC_BOOST_ENABLE_STATUS_OFF)
      rd_data = {5'h00, we_r, pg_r, on_r};  // RULE_01 RULE_06
    else if (ptr_r == `WBC_STRING_CLAMP_SETTING_OFF)
      rd_data = {2'h0, code_r};  // RULE_01
    else
      rd_data = 8'h00;
  end

  // Serial slave state machine; addressing auto-increments after every data byte, read or write
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_r    <= wbc_pkg::WBC_IDLE;
      cnt_r      <= 4'h0;
      shift_r    <= 8'h00;
      ptr_r      <= 8'h00;
      rw_r       <= 1'b0;
      nack_r     <= 1'b0;
      wr_stb_r   <= 1'b0;
      wr_data_r  <= 8'h00;
      wr_addr_r  <= 8'h00;
      sda_oe_out <= 1'b0;
    end
    else
    begin
      wr_stb_r <= 1'b0;
      if (start_det)
      begin
        state_r    <= wbc_pkg::WBC_ADDR;
        cnt_r      <= 4'h0;
        sda_oe_out <= 1'b0;
      end
      else if (stop_det)
      begin
        state_r    <= wbc_pkg::WBC_IDLE;
        sda_oe_out <= 1'b0;
      end
      else
      begin
        case (state_r)
          wbc_pkg::WBC_ADDR, wbc_pkg::WBC_PTR, wbc_pkg::WBC_WDATA:
          begin
            if (scl_rise)
            begin
              shift_r <= {shift_r[6:0], sda_s};
              cnt_r   <= 4'(cnt_r + 4'h1);
            end
            else if (scl_fall && cnt_r == 4'h8)
            begin
              cnt_r <= 4'h0;
              if (state_r == wbc_pkg::WBC_ADDR)
              begin
                rw_r <= shift_r[0];
                if (shift_r[7:1] == DEV_ADDR)
                begin
                  state_r    <= wbc_pkg::WBC_ADDR_ACK;
                  sda_oe_out <= 1'b1;
                end
                else
                  state_r <= wbc_pkg::WBC_IDLE;  // Not ours: stay off the bus
              end
              else if (state_r == wbc_pkg::WBC_PTR)
              begin
                ptr_r      <= shift_r;
                state_r    <= wbc_pkg::WBC_PTR_ACK;
                sda_oe_out <= 1'b1;
              end
              else
              begin
                wr_stb_r   <= 1'b1;
                wr_data_r  <= shift_r;
                wr_addr_r  <= ptr_r;
                ptr_r      <= 8'(ptr_r + 8'h01);
                state_r    <= wbc_pkg::WBC_WDATA_ACK;
                sda_oe_out <= 1'b1;
              end
            end
          end
          wbc_pkg::WBC_ADDR_ACK, wbc_pkg::WBC_PTR_ACK, wbc_pkg::WBC_WDATA_ACK:
          begin
            if (scl_fall)
            begin
              cnt_r <= 4'h0;
              if (state_r == wbc_pkg::WBC_ADDR_ACK && rw_r)
              begin
                state_r    <= wbc_pkg::WBC_RDATA;
                shift_r    <= rd_data;
                sda_oe_out <= ~rd_data[7];
              end
              else
              begin
                state_r    <= (state_r == wbc_pkg::WBC_ADDR_ACK) ? wbc_pkg::WBC_PTR : wbc_pkg::WBC_WDATA;
                sda_oe_out <= 1'b0;
              end
            end
          end
          wbc_pkg::WBC_RDATA:
          begin
            if (scl_fall)
            begin
              if (cnt_r == 4'h7)
              begin
                state_r    <= wbc_pkg::WBC_RDATA_ACK;
                sda_oe_out <= 1'b0;
                ptr_r      <= 8'(ptr_r + 8'h01);
              end
              else
              begin
                shift_r    <= {shift_r[6:0], 1'b0};
                sda_oe_out <= ~shift_r[6];
                cnt_r      <= 4'(cnt_r + 4'h1);
              end
            end
          end
          wbc_pkg::WBC_RDATA_ACK:
          begin
            if (scl_rise)
              nack_r <= sda_s;
            else if (scl_fall)
            begin
              cnt_r <= 4'h0;
              if (nack_r)
                state_r <= wbc_pkg::WBC_IDLE;  // Master is done reading
              else
              begin
                state_r    <= wbc_pkg::WBC_RDATA;
                shift_r    <= rd_data;
                sda_oe_out <= ~rd_data[7];
              end
            end
          end
          default:
          begin
            state_r    <= wbc_pkg::WBC_IDLE;
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open-drain data line only ever pulls low
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  // Writable fields; everything else is dropped without effect
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      on_r   <= `WBC_ON_RST;
      we_r   <= WE_DEFAULT;
      code_r <= `WBC_CLAMP_CODE_RST;  // RULE_11
    end
    else if (wr_stb_r)
    begin
      if (wr_addr_r == `WBC_BOOST_ENABLE_STATUS_OFF)
      begin
        on_r <= wr_data_r[`WBC_ON_BIT];  // RULE_03
        we_r <= wr_data_r[`WBC_WE_BIT];  // RULE_08
      end
      else if (wr_addr_r == `WBC_STRING_CLAMP_SETTING_OFF)
        code_r <= wr_data_r[5:0];  // RULE_09 RULE_12
    end
  end

  // Enable: pin, stored bit or key press; any one suffices
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      en_r <= 1'b0;
    else
      en_r <= pin_s | on_r | ~key_n_s;  // RULE_02 RULE_03 RULE_04 RULE_05
  end

  // Power-good drops at once on over-voltage, even while enabled
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      pg_r <= 1'b0;
    else
      pg_r <= en_r & ~sense_s;  // RULE_06 RULE_07
  end

  // Clamp level to the analog loop, registered
  logic [11:0] clamp_dec;

  wbc_clamp_decode u_decode (
    .code_in   (code_r),
    .clamp_out (clamp_dec)
  );

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      clamp_mv_out <= `WBC_CLAMP_MAX;
    else
      clamp_mv_out <= clamp_dec;  // RULE_10
  end

  assign boost_en_out   = en_r;
  assign power_good_out = pg_r;
  assign clamp_code_out = code_r;

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_RESV_ZERO: assert property ((ptr_r == `WBC_BOOST_ENABLE_STATUS_OFF) |-> rd_data[7:3] == 5'h00)  // RULE_01
    else $error("reserved control bits not zero");
  AST_PIN_EN: assert property (pin_s |=> boost_en_out)  // RULE_02
    else $error("pin high did not enable boost");
  AST_ON_EN: assert property (on_r |=> boost_en_out)  // RULE_03
    else $error("enable bit did not enable boost");
  AST_KEY_EN: assert property (!key_n_s |=> boost_en_out)  // RULE_04
    else $error("key press did not enable boost");
  AST_DIS: assert property ((!pin_s && key_n_s && !on_r) |=> !boost_en_out)  // RULE_05
    else $error("boost on without enable cause");
  AST_PG_SET: assert property ((boost_en_out && !sense_s) |=> power_good_out)  // RULE_06
    else $error("power-good not set");
  AST_SENSE_CLR: assert property (sense_s |=> !power_good_out)  // RULE_07
    else $error("power-good not cleared on over-voltage");
  AST_CODE_WR: assert property ((wr_stb_r && wr_addr_r == `WBC_STRING_CLAMP_SETTING_OFF)
                                |=> clamp_code_out == $past(wr_data_r[5:0]))  // RULE_09
    else $error("clamp code write lost");
  AST_DECODE: assert property ((code_r == 6'h3F) ##1 (code_r == 6'h3F) |-> clamp_mv_out == `WBC_CLAMP_MAX)  // RULE_10
    else $error("clamp decode wrong at top code");
  AST_RST_CODE: assert property ($rose(rst_n_in) |-> clamp_code_out == `WBC_CLAMP_CODE_RST)  // RULE_11
    else $error("clamp code not at maximum after reset");
  AST_RO_WR: assert property ((wr_stb_r && wr_addr_r == `WBC_RESERVED_STATUS_A_OFF)
                              |=> $stable(on_r) && $stable(code_r) && $stable(we_r))  // RULE_12
    else $error("write to read-only register had effect");

  COV_WRITE: cover property (wr_stb_r && wr_addr_r == `WBC_STRING_CLAMP_SETTING_OFF);
  COV_READ: cover property (state_r == wbc_pkg::WBC_RDATA_ACK);
  COV_KEY: cover property (!key_n_s && !pin_s && !on_r ##1 boost_en_out);
  COV_SENSE: cover property (power_good_out ##1 sense_s ##1 !power_good_out);

endmodule // wbc_regs

// file: tb/wbc_host_model.sv
// Serial bus master model standing in for the host processor
module wbc_host_model (
  input  wire logic sys_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_pull_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: clock high, data released to the pull-up
  initial
  begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  // Eight system clocks per phase, twice the slave minimum
  task automatic half;
    repeat (8) @(negedge sys_clk_in);
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start;
    half();
    sda_pull_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_pull_out = 1'b1;
    half();
    scl_out = 1'b0;
  endtask

  // Stop: data rises while the clock is high
  task automatic stop;
    half();
    sda_pull_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_pull_out = 1'b0;
    half();
  endtask

  // Eight bits MSB first plus the acknowledge slot; a 1 releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      // Hold data a little past the clock fall so the slave never sees a false start
      repeat (2) @(negedge sys_clk_in);
      sda_pull_out = ~tx[i];
      half();
      scl_out = 1'b1;
      half();
      rx[i] = sda_in;
      scl_out = 1'b0;
    end
  endtask
endmodule // wbc_host_model

// file: tb/wbc_regs_tb.sv
// Self-checking bench for the boost control register bank
module wbc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [5:0]  code;
    logic [11:0] mv;
    logic        pin, key_n, on, sense, en, pg;
  } wbc_row_t;

  localparam logic [6:0] DEV = 7'h5A;  // Arbitrary bus address

  logic        clk, rst_n, pin, key_n, sense, pull, sda_w, scl;
  logic        sda_out, sda_oe, en_out, pg_out;
  logic [5:0]  code_out;
  logic [11:0] mv_out;
  logic [15:0] r, r0;
  int          failures = 0;
  int          checked = 0;

  // Open-drain wire: low when either party pulls, else the pull-up wins
  assign sda_w = ~(pull | (sda_oe & ~sda_out));

  wbc_regs #(.DEV_ADDR(DEV)) i_dut (
    .sys_clk_in          (clk),
    .rst_n_in            (rst_n),
    .scl_in              (scl),
    .sda_in              (sda_w),
    .sda_out             (sda_out),
    .sda_oe_out          (sda_oe),
    .boost_enable_pin_in (pin),
    .key_press_n_in      (key_n),
    .string_top_sense_in (sense),
    .boost_en_out        (en_out),
    .power_good_out      (pg_out),
    .clamp_code_out      (code_out),
    .clamp_mv_out        (mv_out)
  );

  wbc_host_model i_host (
    .sys_clk_in   (clk),
    .sda_in       (sda_w),
    .scl_out      (scl),
    .sda_pull_out (pull)
  );

  // Ordinary cases: clamp code with its decoded level, and enable inputs with results
  wbc_row_t rows [9] = '{
    '{6'h00, 12'h1F4, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
    '{6'h07, 12'h2A3, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1},
    '{6'h18, 12'h44C, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
    '{6'h1F, 12'h4FB, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1},
    '{6'h20, 12'h514, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0},
    '{6'h27, 12'h672, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
    '{6'h38, 12'h9C4, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1},
    '{6'h3F, 12'hB22, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0},
    '{6'h2A, 12'h708, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0}
  };

  // Free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // Two-byte write; the pointer advances after the first byte
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    logic [7:0] b [4];
    logic [8:0] rx;
    b = '{{DEV, 1'b0}, p, d[15:8], d[7:0]};
    i_host.start();
    for (int i = 0; i < 4; i++)
    begin
      i_host.xfer({b[i], 1'b1}, rx);
      chk_bit(rx[0], 1'b0, "write ack");
    end
    i_host.stop();
  endtask

  // Two-byte read: ack after the first byte, nack after the second
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    logic [8:0] rx;
    i_host.start();
    i_host.xfer({DEV, 2'b01}, rx);
    chk_bit(rx[0], 1'b0, "addr ack");
    i_host.xfer({p, 1'b1}, rx);
    chk_bit(rx[0], 1'b0, "ptr ack");
    i_host.start();
    i_host.xfer({DEV, 2'b11}, rx);
    chk_bit(rx[0], 1'b0, "read ack");
    i_host.xfer(9'h1FE, rx);
    d[15:8] = rx[8:1];
    i_host.xfer(9'h1FF, rx);
    d[7:0] = rx[8:1];
    i_host.stop();
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole run is about 20k clocks; limit at 60k keeps well inside the cycle budget
  initial
  begin
    #1200000;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  // Main sequence; inputs move on the falling edge
  initial
  begin
    {pin, sense, rst_n} = 3'h0;
    key_n = 1'b1;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk_val({10'h000, code_out}, 16'h003F, "reset code");
    chk_val({4'h0, mv_out}, 16'h0B22, "reset level");
    chk_bit(en_out, 1'b0, "reset enable");
    rd(8'h42, r);
    chk_val(r & 16'h073F, 16'h003F, "reset regs");
    $display("reset test done");
    foreach (rows[i])
    begin
      // Bit 2 keeps its default; read-only bits are written as ones
      wr(8'h42, {5'h1F, 1'b0, 1'b1, rows[i].on, 2'b11, rows[i].code});
      pin = rows[i].pin;
      key_n = rows[i].key_n;
      sense = rows[i].sense;
      repeat (6) @(negedge clk);
      chk_bit(en_out, rows[i].en, "enable");
      chk_bit(pg_out, rows[i].pg, "power good");
      chk_val({10'h000, code_out}, {10'h000, rows[i].code}, "code");
      chk_val({4'h0, mv_out}, {4'h0, rows[i].mv}, "level");
      rd(8'h42, r);
      chk_val(r & 16'h073F, {5'h00, 1'b0, rows[i].pg, rows[i].on, 2'b00, rows[i].code}, "readback");
      $display("row %0d done", i);
    end
    // Reserved registers ignore writes, and the live state is untouched
    rd(8'h40, r0);
    wr(8'h40, ~r0);
    rd(8'h40, r);
    chk_val(r, r0, "reserved");
    chk_val({10'h000, code_out}, 16'h002A, "side effect");
    rd(8'h44, r);
    chk_val(r, 16'h0000, "unmapped");
    $display("read-only test done");
    // Foreign address gets no acknowledge
    i_host.start();
    i_host.xfer({DEV ^ 7'h01, 2'b01}, r[8:0]);
    chk_bit(r[0], 1'b1, "stray ack");
    i_host.stop();
    $display("address test done");
    // Second reset in mid-run restores the maximum clamp
    wr(8'h42, 16'h0105);
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk_val({4'h0, mv_out}, 16'h0B22, "rereset level");
    chk_bit(en_out, 1'b0, "rereset enable");
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule // wbc_regs_tb
